// *** src/xcvr_regs.svh ***
/*
 * Register offsets, field positions, reset values and widths of the
 * registered bus transceiver.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`ifndef XCVR_REGS_SVH
`define XCVR_REGS_SVH
`define XCVR_DATA_W 17
`define XCVR_AXI_DATA_W 32
`define XCVR_OFF_CTRL 8'h00
`define XCVR_OFF_STORE_AB 8'h04
`define XCVR_OFF_STORE_BA 8'h08
`define XCVR_CTRL_AB 0
`define XCVR_CTRL_BA 1
`define XCVR_CTRL_LANE 0
`define XCVR_CTRL_RST 2'h3
`define XCVR_RESP_OKAY 2'h0
`define XCVR_RESP_DECERR 2'h3
`endif

// *** src/xcvr_pkg.sv ***
/*
 * Types shared by the transceiver modules.
 * Assumes the constants header is on the include path.
 */
package xcvr_pkg;
`include "xcvr_regs.svh"
    typedef logic [`XCVR_DATA_W-1:0] data_t;
    typedef struct packed {
        logic ab_oe_n;
        logic ba_oe_n;
        logic ab_ce_n;
        logic ba_ce_n;
        logic ab_le;
        logic ba_le;
        logic ab_clk;
        logic ba_clk;
        logic bp_clk;
        data_t a;
        data_t b;
    } pins_t;
    typedef struct packed {
        logic rst_n;
        logic [1:0] permit;
        logic req;
    } to_link_t;
    typedef enum logic [2:0] {
        AX_IDLE = 3'h0,
        AX_WACC = 3'h1,
        AX_WRESP = 3'h2,
        AX_RACC = 3'h3,
        AX_RRESP = 3'h4
    } axi_state_t;
    typedef enum logic [1:0] {
        SEL_CTRL = 2'h0,
        SEL_AB = 2'h1,
        SEL_BA = 2'h2,
        SEL_NONE = 2'h3
    } reg_sel_t;
endpackage

// *** src/xfer_if.sv ***
/*
 * Signals between the top level and one direction's data path.
 * Assumes all of them live in the link clock domain.
 */
`timescale 1ns/1ps
interface xfer_if;
    logic oe_n, ce_n, le, clk, fclk, permit;
    xcvr_pkg::data_t din;
    xcvr_pkg::data_t store;
    xcvr_pkg::data_t pin_o;
    xcvr_pkg::data_t pin_oe;
    logic clk_o, clk_oe, clk_p, le_p;
    modport path (
        input oe_n, ce_n, le, clk, fclk, permit, din,
        output store, pin_o, pin_oe, clk_o, clk_oe, clk_p, le_p
    );
    modport top (
        output oe_n, ce_n, le, clk, fclk, permit, din,
        input store, pin_o, pin_oe, clk_o, clk_oe, clk_p, le_p
    );
endinterface // xfer_if

// *** src/sync_2ff.sv ***
/*
 * Two flip-flop level synchroniser of any width.
 * Assumes each bit is an independent level; words need a handshake.
 */
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;
    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d.meta = d;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign q = s_q.stable;
endmodule // sync_2ff

// *** src/xfer_path.sv ***
/*
 * One direction of the transceiver: storage, mode select and pin drive.
 * Assumes synchronised controls; the storage word has no reset.
 */
`timescale 1ns/1ps
module xfer_path #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    xfer_if.path io
);
    typedef struct packed {
        logic clk_p;
        logic le_p;
        xcvr_pkg::data_t store;
        xcvr_pkg::data_t pin_o;
        xcvr_pkg::data_t pin_oe;
        logic clk_o;
        logic clk_oe;
    } path_state_t;
    path_state_t p_q;
    path_state_t p_d;
    logic capture;
    logic en;
    xcvr_pkg::data_t val;

    always_comb begin
        p_d = p_q;
        p_d.clk_p = io.clk;
        p_d.le_p = io.le;
        capture = !io.ce_n && !io.le && ((io.clk && !p_q.clk_p) || p_q.le_p);
        if (capture) begin
            p_d.store = io.din;
        end
        val = io.le ? io.din : p_d.store;
        en = !io.oe_n && io.permit;
        if (OPEN_DRAIN) begin
            p_d.pin_o = '0;
            p_d.pin_oe = en ? ~val : '0;
            p_d.clk_o = 1'b0;
            p_d.clk_oe = en && !io.fclk;
        end else begin
            p_d.pin_o = val;
            p_d.pin_oe = en ? '1 : '0;
            p_d.clk_o = io.fclk;
            p_d.clk_oe = en;
        end
        // Edge history keeps following the pins in reset, so release
        // never shows a false clock rise or latch fall.
        if (!rst_n) begin
            p_d.pin_o = '0;
            p_d.pin_oe = '0;
            p_d.clk_o = 1'b0;
            p_d.clk_oe = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        p_q <= p_d;
    end

    assign io.store = p_q.store;
    assign io.pin_o = p_q.pin_o;
    assign io.pin_oe = p_q.pin_oe;
    assign io.clk_o = p_q.clk_o;
    assign io.clk_oe = p_q.clk_oe;
    assign io.clk_p = p_q.clk_p;
    assign io.le_p = p_q.le_p;
endmodule // xfer_path

// *** src/registered_bus_transceiver_17b.sv ***
/*
 * Top level of the 17-bit registered bus transceiver: pin synchronisers,
 * both direction paths, the status crossing and an AXI4-Lite slave.
 * Assumes the pins are sampled on link_clk and that a pad ring resolves
 * every output and enable pair into a wire.
 */
`timescale 1ns/1ps
`include "xcvr_regs.svh"

// Function
// - Both ports carry 17 data bits, all handled by the same controls.
// - A-to-B output enable high releases every B-side data output.
// - A-to-B output enable low drives B outputs with the selected value.
// - Latch enable high makes B follow A, ignoring clock and clock enable.
// - Clock enable and latch enable low: capture A on each rising clock.
// - Latch enable falling with clock enable low captures present A data.
// - Clock steady and latch enable low: the stored value stays on B.
// - Clock enable high with latch enable low ignores edges, keeps storage.
// - One clock enable per direction gates all 17 bits together.
// - Each output enable gates its data outputs and buffered clock together.
// - B-to-A mirrors A-to-B with its own enables, latch enable and clock.
// - Clock high at latch fall holds the value; else a rising edge reloads.
// - Buffered A-to-B clock drives the backplane clock line when enabled.
// - Card-side clock output copies the backplane clock line when enabled.
// - B outputs are open-drain, pull low only; backplane supplies pull-up.
// - A pins are inputs one way, three-state outputs when B-to-A enabled.
module registered_bus_transceiver_17b #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic link_clk,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`XCVR_AXI_DATA_W-1:0] wdata,
    input wire logic [`XCVR_AXI_DATA_W/8-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [`XCVR_AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic a_to_b_output_enable_n,
    input wire logic b_to_a_output_enable_n,
    input wire logic a_to_b_clock_enable_n,
    input wire logic b_to_a_clock_enable_n,
    input wire logic a_to_b_latch_enable,
    input wire logic b_to_a_latch_enable,
    input wire logic a_to_b_clock,
    input wire logic b_to_a_clock,
    input wire xcvr_pkg::data_t card_port_data_i,
    output xcvr_pkg::data_t card_port_data_o,
    output xcvr_pkg::data_t card_port_data_oe,
    input wire xcvr_pkg::data_t backplane_port_data_i,
    output xcvr_pkg::data_t backplane_port_data_o,
    output xcvr_pkg::data_t backplane_port_data_oe,
    input wire logic backplane_clock_line_i,
    output logic backplane_clock_line_o,
    output logic backplane_clock_line_oe,
    output logic card_side_buffered_clock_o,
    output logic card_side_buffered_clock_oe
);
    typedef struct packed {
        xcvr_pkg::axi_state_t state;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [`XCVR_AXI_DATA_W-1:0] rdata;
        logic [1:0] permit;
        logic req;
        xcvr_pkg::data_t stat_ab;
        xcvr_pkg::data_t stat_ba;
    } bus_state_t;

    typedef struct packed {
        logic ack;
        xcvr_pkg::data_t hold_ab;
        xcvr_pkg::data_t hold_ba;
    } link_state_t;

    bus_state_t ax_q;
    bus_state_t ax_d;
    link_state_t lk_q;
    link_state_t lk_d;
    xcvr_pkg::pins_t pin_raw;
    xcvr_pkg::pins_t pin_s;
    xcvr_pkg::to_link_t to_link;
    xcvr_pkg::to_link_t link_s;
    logic ack_s;

    xfer_if ab ();
    xfer_if ba ();

    function automatic xcvr_pkg::reg_sel_t reg_sel(
        input logic [ADDR_W-1:0] addr
    );
        if (addr == ADDR_W'(`XCVR_OFF_CTRL)) return xcvr_pkg::SEL_CTRL;
        if (addr == ADDR_W'(`XCVR_OFF_STORE_AB)) return xcvr_pkg::SEL_AB;
        if (addr == ADDR_W'(`XCVR_OFF_STORE_BA)) return xcvr_pkg::SEL_BA;
        return xcvr_pkg::SEL_NONE;
    endfunction

    // Every pin is asynchronous to link_clk, so all of them pass two stages.
    always_comb begin
        pin_raw.ab_oe_n = a_to_b_output_enable_n;
        pin_raw.ba_oe_n = b_to_a_output_enable_n;
        pin_raw.ab_ce_n = a_to_b_clock_enable_n;
        pin_raw.ba_ce_n = b_to_a_clock_enable_n;
        pin_raw.ab_le = a_to_b_latch_enable;
        pin_raw.ba_le = b_to_a_latch_enable;
        pin_raw.ab_clk = a_to_b_clock;
        pin_raw.ba_clk = b_to_a_clock;
        pin_raw.bp_clk = backplane_clock_line_i;
        pin_raw.a = card_port_data_i;
        pin_raw.b = backplane_port_data_i;
    end

    sync_2ff #(
        .W($bits(xcvr_pkg::pins_t))
    ) u_pin_sync (
        .clk(link_clk),
        .d(pin_raw),
        .q(pin_s)
    );

    always_comb begin
        to_link.rst_n = aresetn;
        to_link.permit = ax_q.permit;
        to_link.req = ax_q.req;
    end

    sync_2ff #(
        .W($bits(xcvr_pkg::to_link_t))
    ) u_to_link (
        .clk(link_clk),
        .d(to_link),
        .q(link_s)
    );

    sync_2ff #(
        .W(1)
    ) u_to_bus (
        .clk(aclk),
        .d(lk_q.ack),
        .q(ack_s)
    );

    assign ab.oe_n = pin_s.ab_oe_n;
    assign ab.ce_n = pin_s.ab_ce_n;
    assign ab.le = pin_s.ab_le;
    assign ab.clk = pin_s.ab_clk;
    assign ab.fclk = pin_s.ab_clk;
    assign ab.permit = link_s.permit[`XCVR_CTRL_AB];
    assign ab.din = pin_s.a;

    assign ba.oe_n = pin_s.ba_oe_n;
    assign ba.ce_n = pin_s.ba_ce_n;
    assign ba.le = pin_s.ba_le;
    assign ba.clk = pin_s.ba_clk;
    assign ba.fclk = pin_s.bp_clk;
    assign ba.permit = link_s.permit[`XCVR_CTRL_BA];
    assign ba.din = pin_s.b;

    xfer_path #(
        .OPEN_DRAIN(1'b1)
    ) u_a_to_b (
        .clk(link_clk),
        .rst_n(link_s.rst_n),
        .io(ab)
    );

    xfer_path #(
        .OPEN_DRAIN(1'b0)
    ) u_b_to_a (
        .clk(link_clk),
        .rst_n(link_s.rst_n),
        .io(ba)
    );

    assign backplane_port_data_o = ab.pin_o;
    assign backplane_port_data_oe = ab.pin_oe;
    assign backplane_clock_line_o = ab.clk_o;
    assign backplane_clock_line_oe = ab.clk_oe;
    assign card_port_data_o = ba.pin_o;
    assign card_port_data_oe = ba.pin_oe;
    assign card_side_buffered_clock_o = ba.clk_o;
    assign card_side_buffered_clock_oe = ba.clk_oe;

    // The hold words change only when the request toggle moves, so the bus
    // side may read them once the answering toggle has come through.
    always_comb begin
        lk_d = lk_q;
        if (link_s.req != lk_q.ack) begin
            lk_d.hold_ab = ab.store;
            lk_d.hold_ba = ba.store;
            lk_d.ack = link_s.req;
        end
        if (!link_s.rst_n) begin
            lk_d = '0;
        end
    end

    always_ff @(posedge link_clk) begin
        lk_q <= lk_d;
    end

    always_comb begin
        ax_d = ax_q;
        if (ack_s == ax_q.req) begin
            ax_d.stat_ab = lk_q.hold_ab;
            ax_d.stat_ba = lk_q.hold_ba;
            ax_d.req = !ax_q.req;
        end
        unique case (ax_q.state)
            xcvr_pkg::AX_IDLE: begin
                if (awvalid && wvalid) begin
                    ax_d.awready = 1'b1;
                    ax_d.wready = 1'b1;
                    ax_d.state = xcvr_pkg::AX_WACC;
                end else if (arvalid) begin
                    ax_d.arready = 1'b1;
                    ax_d.state = xcvr_pkg::AX_RACC;
                end
            end
            xcvr_pkg::AX_WACC: begin
                ax_d.awready = 1'b0;
                ax_d.wready = 1'b0;
                ax_d.bvalid = 1'b1;
                ax_d.bresp = `XCVR_RESP_OKAY;
                ax_d.state = xcvr_pkg::AX_WRESP;
                unique case (reg_sel(awaddr))
                    xcvr_pkg::SEL_CTRL: begin
                        if (wstrb[`XCVR_CTRL_LANE]) begin
                            ax_d.permit[`XCVR_CTRL_AB] =
                                wdata[`XCVR_CTRL_AB];
                            ax_d.permit[`XCVR_CTRL_BA] =
                                wdata[`XCVR_CTRL_BA];
                        end
                    end
                    xcvr_pkg::SEL_AB, xcvr_pkg::SEL_BA: begin
                        ax_d.bresp = `XCVR_RESP_OKAY;
                    end
                    xcvr_pkg::SEL_NONE: begin
                        ax_d.bresp = `XCVR_RESP_DECERR;
                    end
                endcase
            end
            xcvr_pkg::AX_WRESP: begin
                if (bready) begin
                    ax_d.bvalid = 1'b0;
                    ax_d.state = xcvr_pkg::AX_IDLE;
                end
            end
            xcvr_pkg::AX_RACC: begin
                ax_d.arready = 1'b0;
                ax_d.rvalid = 1'b1;
                ax_d.rresp = `XCVR_RESP_OKAY;
                ax_d.state = xcvr_pkg::AX_RRESP;
                unique case (reg_sel(araddr))
                    xcvr_pkg::SEL_CTRL: begin
                        ax_d.rdata = `XCVR_AXI_DATA_W'(ax_q.permit);
                    end
                    xcvr_pkg::SEL_AB: begin
                        ax_d.rdata = `XCVR_AXI_DATA_W'(ax_q.stat_ab);
                    end
                    xcvr_pkg::SEL_BA: begin
                        ax_d.rdata = `XCVR_AXI_DATA_W'(ax_q.stat_ba);
                    end
                    xcvr_pkg::SEL_NONE: begin
                        ax_d.rdata = '0;
                        ax_d.rresp = `XCVR_RESP_DECERR;
                    end
                endcase
            end
            xcvr_pkg::AX_RRESP: begin
                if (rready) begin
                    ax_d.rvalid = 1'b0;
                    ax_d.state = xcvr_pkg::AX_IDLE;
                end
            end
            default: begin
                ax_d.state = xcvr_pkg::AX_IDLE;
            end
        endcase
        if (!aresetn) begin
            ax_d = '0;
            ax_d.state = xcvr_pkg::AX_IDLE;
            ax_d.permit = `XCVR_CTRL_RST;
        end
    end

    always_ff @(posedge aclk) begin
        ax_q <= ax_d;
    end

    assign awready = ax_q.awready;
    assign wready = ax_q.wready;
    assign bvalid = ax_q.bvalid;
    assign bresp = ax_q.bresp;
    assign arready = ax_q.arready;
    assign rvalid = ax_q.rvalid;
    assign rresp = ax_q.rresp;
    assign rdata = ax_q.rdata;

    sequence s_ab_rise;
        !ab.ce_n && !ab.le && ab.clk && !ab.clk_p;
    endsequence

    sequence s_ab_le_fall;
        !ab.ce_n && !ab.le && ab.le_p;
    endsequence

    sequence s_ba_rise;
        !ba.ce_n && !ba.le && ba.clk && !ba.clk_p;
    endsequence

    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence

    property p_ab_clocked;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        s_ab_rise |=> ab.store == $past(ab.din);
    endproperty
    a_ab_clocked: assert property (p_ab_clocked)
        else $error("A-to-B rising clock did not capture A data.");

    property p_ab_latch_fall;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        s_ab_le_fall |=> ab.store == $past(ab.din);
    endproperty
    a_ab_latch_fall: assert property (p_ab_latch_fall)
        else $error("A-to-B latch fall did not capture A data.");

    property p_ab_inhibit;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        ab.ce_n && !ab.le |=> $stable(ab.store);
    endproperty
    a_ab_inhibit: assert property (p_ab_inhibit)
        else $error("A-to-B storage changed with clock enable high.");

    property p_ab_hold;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        !ab.le && !ab.le_p && (ab.clk == ab.clk_p)
            |=> $stable(ab.store);
    endproperty
    a_ab_hold: assert property (p_ab_hold)
        else $error("A-to-B storage changed with a steady clock.");

    property p_ab_off;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        ab.oe_n |=> backplane_port_data_oe == '0 && !backplane_clock_line_oe;
    endproperty
    a_ab_off: assert property (p_ab_off)
        else $error("B side driven while its output enable is high.");

    property p_ab_transparent;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        !ab.oe_n && ab.permit && ab.le
            |=> backplane_port_data_oe == ~$past(ab.din)
                && backplane_port_data_o == '0;
    endproperty
    a_ab_transparent: assert property (p_ab_transparent)
        else $error("B side did not follow A in transparent mode.");

    property p_ba_clocked;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        s_ba_rise |=> ba.store == $past(ba.din);
    endproperty
    a_ba_clocked: assert property (p_ba_clocked)
        else $error("B-to-A rising clock did not capture B data.");

    property p_ba_drive;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        !ba.oe_n && ba.permit && ba.le
            |=> card_port_data_o == $past(ba.din) && card_port_data_oe == '1;
    endproperty
    a_ba_drive: assert property (p_ba_drive)
        else $error("A side not driven with B data when enabled.");

    property p_ba_off;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        ba.oe_n |=> card_port_data_oe == '0 && !card_side_buffered_clock_oe;
    endproperty
    a_ba_off: assert property (p_ba_off)
        else $error("A side driven while its output enable is high.");

    property p_clk_fwd;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        !ab.oe_n && ab.permit
            |=> backplane_clock_line_oe == !$past(ab.fclk);
    endproperty
    a_clk_fwd: assert property (p_clk_fwd)
        else $error("Backplane clock line does not copy A-to-B clock.");

    property p_card_clk;
        @(posedge link_clk) disable iff (!link_s.rst_n)
        !ba.oe_n && ba.permit
            |=> card_side_buffered_clock_oe
                && card_side_buffered_clock_o == $past(ba.fclk);
    endproperty
    a_card_clk: assert property (p_card_clk)
        else $error("Card clock does not copy the backplane clock line.");

    property p_wr_answer;
        @(posedge aclk) disable iff (!aresetn)
        s_wr_taken |=> bvalid ##1 (bvalid || $past(bready));
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("Write response missing after write was taken.");

    property p_rd_hold;
        @(posedge aclk) disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("Read response changed before it was taken.");
endmodule // registered_bus_transceiver_17b

// *** testbench/bp_model.sv ***
/*
 * Far side of the transceiver: wired-OR backplane with pull-up and the
 * card logic that shares the A pins with the device.
 * Assumes active-high pull-low enables from every backplane driver.
 */
`timescale 1ns/1ps
module bp_model (
    input wire xcvr_pkg::data_t b_oe,
    input wire xcvr_pkg::data_t ext_pull,
    input wire xcvr_pkg::data_t a_o,
    input wire xcvr_pkg::data_t a_oe,
    input wire xcvr_pkg::data_t card_drv,
    input wire logic clk_oe,
    input wire logic ext_clk,
    output xcvr_pkg::data_t b_wire,
    output xcvr_pkg::data_t a_wire,
    output logic clk_wire
);
    // Any driver pulling low wins; the termination supplies the high.
    assign b_wire = ~(b_oe | ext_pull);
    assign clk_wire = ~(clk_oe | ext_clk);
    // Card logic only drives bits the device has released.
    assign a_wire = (a_oe & a_o) | (~a_oe & card_drv);
endmodule // bp_model

// *** testbench/registered_bus_transceiver_17b_tb.sv ***
/*
 * Self-checking bench for the 17-bit registered bus transceiver.
 * Assumes the backplane model resolves all pin wires.
 */
`timescale 1ns/1ps
`include "xcvr_regs.svh"
module registered_bus_transceiver_17b_tb;
logic aclk = 0, aresetn = 0, lclk = 0, xclk = 0;
logic [7:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, rv, rdata, seed = 32'h52;
logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic awready, wready, bvalid, arready, rvalid, cloe, cco, ccoe, cw;
logic [1:0] bresp, rresp, rs;
logic aoen = 1, boen = 1, acen = 1, bcen = 1, ale = 0, ble = 0;
logic ack = 0, bck = 0, clo;
logic [3:0] ws = 4'hF;
xcvr_pkg::data_t bpo;
xcvr_pkg::data_t a_drv = 0, xpull = 0, a_o, a_oe, b_oe, bw, aw, m_ab, v;
int n_fail = 0, checks_done = 0, cyc = 0;
bp_model bp_u (.b_oe(b_oe), .ext_pull(xpull), .a_o(a_o), .a_oe(a_oe),
    .card_drv(a_drv), .clk_oe(cloe), .ext_clk(xclk), .b_wire(bw),
    .a_wire(aw), .clk_wire(cw));
registered_bus_transceiver_17b dut_u (.aclk, .aresetn, .link_clk(lclk),
    .awaddr, .awvalid, .awready, .wdata, .wstrb(ws), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .a_to_b_output_enable_n(aoen),
    .b_to_a_output_enable_n(boen), .a_to_b_clock_enable_n(acen),
    .b_to_a_clock_enable_n(bcen), .a_to_b_latch_enable(ale),
    .b_to_a_latch_enable(ble), .a_to_b_clock(ack), .b_to_a_clock(bck),
    .card_port_data_i(aw), .card_port_data_o(a_o), .card_port_data_oe(a_oe),
    .backplane_port_data_i(bw), .backplane_port_data_o(bpo),
    .backplane_port_data_oe(b_oe), .backplane_clock_line_i(cw),
    .backplane_clock_line_o(clo), .backplane_clock_line_oe(cloe),
    .card_side_buffered_clock_o(cco), .card_side_buffered_clock_oe(ccoe));
initial forever #5 aclk = ~aclk;
initial begin
    #7;
    forever #15 lclk = ~lclk;
end
always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
        n_fail++;
        close_out();
    end
end
function xcvr_pkg::data_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[16:0];
endfunction
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
        n_fail++;
        $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
endtask
task close_out();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
task lc(input int k);
    repeat (k) @(posedge lclk);
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 0; wvalid <= 0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp; bready <= 0;
endtask
task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rv = rdata; rs = rresp; rready <= 0;
endtask
// Pulses last three link cycles so the sampled pins cannot miss them.
task clk_ab();
    @(posedge lclk) ack <= 1;
    lc(3); ack <= 0;
    lc(3);
endtask
initial begin
    repeat (13) @(posedge aclk);
    aresetn <= 1;
    lc(6);
    rd(`XCVR_OFF_CTRL);
    chk("ctrl reset", 32'h3, rv);
    @(posedge lclk) {aoen, ale, acen} <= 3'b010;
    for (int i = 0; i < 4; i++) begin
        @(posedge lclk) a_drv <= rnd();
        lc(6); chk("transparent", a_drv, bw);
        chk("b out low", 0, bpo); chk("clk out low", 0, clo);
    end
    m_ab = a_drv;
    @(posedge lclk) ale <= 0;
    lc(3); v = rnd();
    @(posedge lclk) a_drv <= v;
    lc(6); chk("latch fall low", m_ab, bw);
    clk_ab(); m_ab = v; chk("clocked", m_ab, bw);
    v = rnd();
    @(posedge lclk) begin acen <= 1; a_drv <= v; end
    lc(3); clk_ab(); chk("inhibit", m_ab, bw);
    rd(`XCVR_OFF_STORE_AB);
    chk("store ab", {15'h0, m_ab}, rv);
    @(posedge lclk) {acen, ale, ack} <= 3'b011;
    lc(6); m_ab = a_drv;
    @(posedge lclk) ale <= 0;
    lc(3); v = rnd();
    @(posedge lclk) a_drv <= v;
    lc(6); chk("latch fall high", m_ab, bw);
    chk("clock line high", 1, cw);
    @(posedge lclk) ack <= 0;
    lc(6); chk("clock line low", 0, cw);
    @(posedge lclk) aoen <= 1;
    lc(6); chk("b released", 17'h1FFFF, bw);
    chk("b oe", 0, b_oe); chk("clock oe", 0, cloe);
    @(posedge lclk) {boen, ble, bcen} <= 3'b010;
    for (int i = 0; i < 3; i++) begin
        v = rnd();
        @(posedge lclk) begin xpull <= v; xclk <= i[0]; end
        lc(6); chk("b to a", xcvr_pkg::data_t'(~v), aw);
        chk("card clock", !i[0], cco); chk("card oe", 1, ccoe);
    end
    @(posedge aclk) ws <= 4'hE;
    wr(`XCVR_OFF_CTRL, 32'h0);
    rd(`XCVR_OFF_CTRL);
    chk("ctrl lane off", 32'h3, rv);
    @(posedge aclk) ws <= 4'hF;
    wr(`XCVR_OFF_CTRL, 32'h0);
    lc(8); chk("permit off", 0, a_oe);
    wr(`XCVR_OFF_CTRL, 32'h3);
    chk("bresp", `XCVR_RESP_OKAY, rs);
    @(posedge lclk) boen <= 1;
    lc(6); chk("a released", 0, a_oe);
    chk("card clock oe", 0, ccoe);
    rd(8'h40);
    chk("decerr", `XCVR_RESP_DECERR, rs); chk("unmapped data", 0, rv);
    close_out();
end
endmodule // registered_bus_transceiver_17b_tb
